// file: inc/relay_port_pkg.sv
// Constants and carrier types for the isolated input / relay output port.
// Assumes a host byte bus with one-cycle read and write strobes.
package relay_port_pkg;
   localparam int          ADDR_W       = 2;
   localparam int          DATA_W       = 8;
   localparam logic [1:0]  OFF_RELAY    = 2'h0;
   localparam logic [1:0]  OFF_INPUT    = 2'h1;
   localparam logic [1:0]  OFF_IRQ      = 2'h2;
   localparam logic [1:0]  OFF_FILTER   = 2'h3;
   localparam logic [7:0]  RELAY_RESET  = 8'h00;
   localparam logic [7:0]  UNDEF_READ   = 8'h00;
   localparam int          CLK_HZ       = 50_000_000;
   localparam int          FILTER_MS    = 10;
   // Least filter time in whole cycles: cycles per ms times FILTER_MS
   localparam int          FILTER_CYC   = (CLK_HZ / 1000) * FILTER_MS;
   localparam int          FCNT_W       = 20;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [1:0] addr;
      logic [7:0] wdata;
   } host_req_t;
endpackage

// file: verilog/relay_port.sv
// Isolated input / relay output port: four byte locations on the host bus.
// Host strobes rd/wr for one clock each; inputs arrive from field pins.
`timescale 1ns/10ps
`default_nettype none
module relay_port #(
   parameter int FILTER_CYCLES = relay_port_pkg::FILTER_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire relay_port_pkg::host_req_t req,
   output logic [7:0]                 rdata,
   input  wire logic [7:0]            isolatedInput,
   output logic [7:0]                 relayDrive,
   output logic                       irq,
   output logic                       filterOn
);
   logic [7:0]              inMeta_r;
   logic [7:0]              inSync_r;
   logic [7:0]              inClean_r;
   logic [7:0]              inPrev_r;
   logic [7:0]              relay_r;
   logic [7:0]              rdata_r;
   logic                    irqEn_r;
   logic                    irq_r;
   logic                    filter_r;
   logic [relay_port_pkg::FCNT_W-1:0] fcnt_r [8];
   logic                    change;

   function automatic logic hit(input relay_port_pkg::host_req_t r,
                                input logic [1:0] off);
      hit = (r.addr == off);
   endfunction

   wire rdIrq  = req.rd && hit(req, relay_port_pkg::OFF_IRQ);
   wire wrIrq  = req.wr && hit(req, relay_port_pkg::OFF_IRQ);
   wire rdFilt = req.rd && hit(req, relay_port_pkg::OFF_FILTER);
   wire wrFilt = req.wr && hit(req, relay_port_pkg::OFF_FILTER);
   wire wrClr  = req.wr && hit(req, relay_port_pkg::OFF_INPUT);
   wire wrRel  = req.wr && hit(req, relay_port_pkg::OFF_RELAY);

   // Field pins are asynchronous
   always_ff @(posedge clk) begin
      if (!rstn) begin
         inMeta_r <= 8'h00;
         inSync_r <= 8'h00;
      end else begin
         inMeta_r <= isolatedInput;
         inSync_r <= inMeta_r;
      end
   end

   // Per-channel filter: a new level must hold for the full time
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : gFilt
         always_ff @(posedge clk) begin
            if (!rstn) begin
               fcnt_r[g]    <= '0;
               inClean_r[g] <= 1'b0;
            end else if (!filter_r || inSync_r[g] == inClean_r[g]) begin
               fcnt_r[g]    <= '0;
               inClean_r[g] <= inSync_r[g];
            end else if (fcnt_r[g] >=
                         relay_port_pkg::FCNT_W'(FILTER_CYCLES - 1)) begin
               fcnt_r[g]    <= '0;
               inClean_r[g] <= inSync_r[g];
            end else begin
               fcnt_r[g]    <= fcnt_r[g] + 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rstn) filter_r <= 1'b0;
      else if (rdFilt) filter_r <= 1'b1;
      else if (wrFilt) filter_r <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (!rstn) relay_r <= relay_port_pkg::RELAY_RESET;
      else if (wrRel) relay_r <= req.wdata;
   end

   always_ff @(posedge clk) begin
      if (!rstn) irqEn_r <= 1'b0;
      else if (rdIrq) irqEn_r <= 1'b1;
      else if (wrIrq) irqEn_r <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (!rstn) inPrev_r <= 8'h00;
      else inPrev_r <= inClean_r;
   end
   assign change = |(inPrev_r ^ inClean_r);

   // A change in the clearing cycle still wins, so no edge is lost
   always_ff @(posedge clk) begin
      if (!rstn) irq_r <= 1'b0;
      else if (wrIrq) irq_r <= 1'b0;
      else if (irqEn_r && change) irq_r <= 1'b1;
      else if (wrClr) irq_r <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (!rstn) rdata_r <= 8'h00;
      else if (req.rd) begin
         unique case (req.addr)
            relay_port_pkg::OFF_RELAY: rdata_r <= relay_r;
            relay_port_pkg::OFF_INPUT: rdata_r <= inClean_r;
            relay_port_pkg::OFF_IRQ: rdata_r <= relay_port_pkg::UNDEF_READ;
            relay_port_pkg::OFF_FILTER: rdata_r <=
               relay_port_pkg::UNDEF_READ;
         endcase
      end
   end

   assign rdata      = rdata_r;
   assign relayDrive = relay_r;
   assign irq        = irq_r;
   assign filterOn   = filter_r;

   // Relay load spans the strobe edge and the one after it
   sequence sWrRelay;
      wrRel ##1 1'b1;
   endsequence

   // Two quiet cycles, so an enable read right after cannot sneak in
   sequence sIrqQuiet;
      !irq ##1 !irq;
   endsequence

   chk_relay_load: assert property (
      @(posedge clk) disable iff (!rstn)
      sWrRelay |-> relayDrive == $past(req.wdata))
      else $error("relay latch not loaded");
   chk_relay_hold: assert property (
      @(posedge clk) disable iff (!rstn)
      !wrRel |=> $stable(relayDrive))
      else $error("relay latch changed without write");
   chk_relay_read: assert property (
      @(posedge clk) disable iff (!rstn)
      (req.rd && req.addr == relay_port_pkg::OFF_RELAY && !wrRel)
      |=> rdata == relayDrive)
      else $error("relay readback wrong");
   chk_filter_on: assert property (
      @(posedge clk) disable iff (!rstn)
      rdFilt |=> filterOn)
      else $error("filter not enabled");
   chk_filter_off: assert property (
      @(posedge clk) disable iff (!rstn)
      (wrFilt && !rdFilt) |=> !filterOn)
      else $error("filter not disabled");
   chk_filter_hold: assert property (
      @(posedge clk) disable iff (!rstn)
      (!rdFilt && !wrFilt) |=> $stable(filterOn))
      else $error("filter changed without strobe");
   chk_irq_clear: assert property (
      @(posedge clk) disable iff (!rstn)
      (wrClr && !(irqEn_r && change)) |=> !irq)
      else $error("irq not cleared");
   chk_clr_keeps: assert property (
      @(posedge clk) disable iff (!rstn)
      wrClr |=> $stable(relayDrive) && $stable(filterOn))
      else $error("clear write disturbed state");
   chk_irq_arm: assert property (
      @(posedge clk) disable iff (!rstn)
      rdIrq |=> irqEn_r)
      else $error("irq not enabled");
   chk_irq_disable: assert property (
      @(posedge clk) disable iff (!rstn)
      wrIrq |=> sIrqQuiet)
      else $error("irq after disable");
   chk_irq_quiet: assert property (
      @(posedge clk) disable iff (!rstn)
      (!irqEn_r && !irq) |=> !irq)
      else $error("irq raised while disabled");
   chk_irq_raise: assert property (
      @(posedge clk) disable iff (!rstn)
      (irqEn_r && change && !wrIrq) |=> irq)
      else $error("irq not raised");
   chk_irq_sticky: assert property (
      @(posedge clk) disable iff (!rstn)
      (irq && !wrIrq && !wrClr) |=> irq)
      else $error("irq dropped early");
   chk_in_read: assert property (
      @(posedge clk) disable iff (!rstn)
      (req.rd && req.addr == relay_port_pkg::OFF_INPUT)
      |=> rdata == $past(inClean_r))
      else $error("input read wrong");
   chk_undef_read: assert property (
      @(posedge clk) disable iff (!rstn)
      (rdIrq || rdFilt) |=> rdata == relay_port_pkg::UNDEF_READ)
      else $error("strobe read returned data");
   chk_rdata_hold: assert property (
      @(posedge clk) disable iff (!rstn)
      !req.rd |=> $stable(rdata))
      else $error("read data changed without read");
   chk_no_filter: assert property (
      @(posedge clk) disable iff (!rstn)
      !filterOn ##1 !filterOn |-> inClean_r == $past(inSync_r))
      else $error("unfiltered input lags");
   chk_relay_reset: assert property (
      @(posedge clk)
      !rstn |=> relayDrive == relay_port_pkg::RELAY_RESET)
      else $error("relay not cleared at reset");
endmodule
`default_nettype wire

// file: tb/host_model.sv
// Host bus master model: one-cycle byte read and write strobes.
// Assumes the caller starts just after a rising edge of clk.
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input  wire logic                     clk,
   output var relay_port_pkg::host_req_t req
);
   initial req = '0;

   // Strobe stands for one edge; released fields are scrambled
   task automatic access(input logic wr, input logic [1:0] addr,
                         input logic [7:0] data);
      req <= {!wr, wr, addr, data};
      @(posedge clk) #1;
      req <= {1'b0, 1'b0, ~addr, ~data};
      @(posedge clk) #1;
   endtask
endmodule
`default_nettype wire

// file: tb/relay_port_test.sv
// Self-checking bench for the relay port, random and corner stimulus.
// Assumes a short filter parameter so filtered inputs settle quickly.
`timescale 1ns/10ps
`default_nettype none
module relay_port_test;
   logic                      clk = 1'b0;
   logic                      rstn = 1'b0;
   logic [7:0]                pins = 8'h00;
   relay_port_pkg::host_req_t req;
   logic [7:0]                rdata, relayDrive, v, relayExp;
   logic                      irq, filterOn;
   logic [31:0]               seed = 32'hcb19;
   int                        mismatches = 0, cmp_count = 0, cycles = 0, i;

   always #10 clk = ~clk;

   relay_port #(.FILTER_CYCLES(8)) i_relay_port (.clk(clk), .rstn(rstn),
      .req(req), .rdata(rdata), .isolatedInput(pins),
      .relayDrive(relayDrive), .irq(irq), .filterOn(filterOn));
   host_model i_host_model (.clk(clk), .req(req));

   function automatic logic [7:0] bitOf(input int n);
      return 8'h01 << n;
   endfunction

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic wr, input logic [1:0] a);
      i_host_model.access(wr, a, 8'(seed));
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic conclude;
      $display("counts: %0d mismatches, %0d compares", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         conclude();
      end
   end

   initial begin
      idle(3);
      rstn = 1'b1;
      cmp(relayDrive, 8'h00);
      cmp({6'h0, irq, filterOn}, 8'h00);
      for (i = 0; i < 10; i++) begin
         relayExp = (i == 0) ? 8'h81 : (i == 1) ? 8'h20 : $random(seed);
         i_host_model.access(1'b1, relay_port_pkg::OFF_RELAY, relayExp);
         cmp(relayDrive, relayExp);
         acc(1'b0, relay_port_pkg::OFF_RELAY);
         cmp(rdata, relayExp);
         cmp(relayDrive, relayExp);
      end
      $display("relay test done");
      for (i = 0; i < 12; i++) begin
         v = (i < 8) ? bitOf(i) : $random(seed);
         pins = v;
         idle(6);
         acc(1'b0, relay_port_pkg::OFF_INPUT);
         cmp(rdata, v);
         cmp({7'h0, irq}, 8'h00);
      end
      $display("input test done");
      acc(1'b0, relay_port_pkg::OFF_IRQ);
      cmp(rdata, relay_port_pkg::UNDEF_READ);
      pins = ~v;
      idle(6);
      cmp({7'h0, irq}, 8'h01);
      idle(20);
      cmp({7'h0, irq}, 8'h01);
      acc(1'b1, relay_port_pkg::OFF_INPUT);
      cmp({7'h0, irq}, 8'h00);
      cmp(relayDrive, relayExp);
      pins = v;
      idle(6);
      cmp({7'h0, irq}, 8'h01);
      acc(1'b1, relay_port_pkg::OFF_IRQ);
      cmp({7'h0, irq}, 8'h00);
      pins = ~v;
      idle(6);
      cmp({7'h0, irq}, 8'h00);
      $display("interrupt test done");
      acc(1'b0, relay_port_pkg::OFF_FILTER);
      cmp(rdata, relay_port_pkg::UNDEF_READ);
      cmp({7'h0, filterOn}, 8'h01);
      // Short pulse must be swallowed while filtering
      pins = v;
      idle(4);
      acc(1'b0, relay_port_pkg::OFF_INPUT);
      cmp(rdata, ~v);
      pins = ~v;
      idle(20);
      acc(1'b0, relay_port_pkg::OFF_INPUT);
      cmp(rdata, ~v);
      pins = v;
      idle(20);
      acc(1'b0, relay_port_pkg::OFF_INPUT);
      cmp(rdata, v);
      acc(1'b1, relay_port_pkg::OFF_FILTER);
      cmp({7'h0, filterOn}, 8'h00);
      $display("filter test done");
      i_host_model.access(1'b1, relay_port_pkg::OFF_RELAY, 8'hff);
      acc(1'b0, relay_port_pkg::OFF_IRQ);
      rstn = 1'b0;
      idle(3);
      rstn = 1'b1;
      cmp(relayDrive, relay_port_pkg::RELAY_RESET);
      pins = ~pins;
      idle(6);
      cmp({7'h0, irq}, 8'h00);
      $display("reset test done");
      conclude();
   end
endmodule
`default_nettype wire
